// *** verilog/gpc_defines.vh ***
// Constants for the GPIO and PWM port control block
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_CLK_HZ 40000000
`define GPC_SAMPLE_HZ 32
`define GPC_PWM_HZ 100
`define GPC_PWM_STEPS 100
`define GPC_PWM_LAST 7'h63
`define GPC_SAMPLE_CYC (`GPC_CLK_HZ / `GPC_SAMPLE_HZ)
`define GPC_PWM_STEP_CYC (`GPC_CLK_HZ / (`GPC_PWM_HZ * `GPC_PWM_STEPS))
`define GPC_NUM_IO 5
`define GPC_NUM_PIN 13
`define GPC_LEVEL_HIGH 8'h64
`define GPC_CFG_VALID_MASK 8'h0F
`define GPC_CFG_FUNC_BIT 3
`define GPC_ST_LEVEL_BIT 0
`define GPC_ST_FALL_BIT 1
`define GPC_ST_RISE_BIT 2
`define GPC_CMD_SET 8'h22
`define GPC_CMD_READ 8'h23
`define GPC_RSP_SET 8'h62
`define GPC_RSP_READ 8'h63
`define GPC_LEN_SET_VALUE 8'h02
`define GPC_LEN_SET_CFG 8'h03
`define GPC_LEN_READ 8'h01
`define GPC_LEN_READ_RSP 8'h04
`define GPC_RSP_NONE 8'h00
`define GPC_DM_PD_UP 3'h0
`define GPC_DM_STRONG 3'h1
`define GPC_DM_HIZ 3'h2
`define GPC_DM_PU_DN 3'h3
`define GPC_DM_SLOWUP_HIZ 3'h4
`define GPC_DM_SLOW 3'h5
`define GPC_DM_RESERVED 3'h6
`define GPC_DM_HIZ_SLOWDN 3'h7
// APB register byte addresses
`define GPC_ADDR_CMD 12'h000
`define GPC_ADDR_DATA 12'h004
`define GPC_ADDR_RSP 12'h008
`define GPC_ADDR_RDATA 12'h00C
`define GPC_ADDR_BOOT 12'h010
`define GPC_BOOT_STORE_BIT 0
`define GPC_BOOT_LOAD_BIT 1
`endif

// *** verilog/gpc_port_control.v ***
// GPIO and LED line controller: command decode, PWM, input sampling, APB access
//
// The implementer's own choices: register access over APB and the register addresses.
`default_nettype none
`include "gpc_defines.vh"

module gpc_port_control #(
	parameter SAMPLE_CYC = `GPC_SAMPLE_CYC,
	parameter PWM_STEP_CYC = `GPC_PWM_STEP_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [`GPC_NUM_IO-1:0] io_in,
	output reg [`GPC_NUM_IO-1:0] io_out,
	output reg [`GPC_NUM_IO-1:0] io_oe,
	output reg [`GPC_NUM_IO-1:0] io_pull_up,
	output reg [`GPC_NUM_IO-1:0] io_pull_down,
	output reg [`GPC_NUM_IO-1:0] io_slow,
	output reg [`GPC_NUM_IO-1:0] io_user_mode,
	output reg [`GPC_NUM_PIN-`GPC_NUM_IO-1:0] output_only_line,
	output reg [`GPC_NUM_PIN-`GPC_NUM_IO-1:0] output_only_oe,
	output reg [`GPC_NUM_PIN-`GPC_NUM_IO-1:0] output_only_slow
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function valid_index;
		input [7:0] idx;
		begin
			valid_index = (idx < `GPC_NUM_PIN);
		end
	endfunction

	function is_io;
		input [7:0] idx;
		begin
			is_io = (idx < `GPC_NUM_IO);
		end
	endfunction

	function level_ok;
		input [7:0] lvl;
		begin
			level_ok = (lvl <= `GPC_LEVEL_HIGH);
		end
	endfunction

	function cfg_ok;
		input [7:0] cfg;
		begin
			cfg_ok = ((cfg & ~`GPC_CFG_VALID_MASK) == 8'h00);
		end
	endfunction

	// Reply state byte for one pin: reserved bits, rise, fall, level
	function [7:0] status_of;
		input rise;
		input fall;
		input level;
		begin
			status_of = {5'h00, rise, fall, level};
		end
	endfunction

	// Drive for a commanded bit: {oe, pull_up, pull_down, slow}
	function [3:0] drive_of;
		input [2:0] mode;
		input bit_val;
		begin
			case (mode)
			`GPC_DM_PD_UP: drive_of = bit_val ? 4'h8 : 4'h2;
			`GPC_DM_STRONG: drive_of = 4'h8;
			`GPC_DM_HIZ: drive_of = 4'h0;
			`GPC_DM_PU_DN: drive_of = bit_val ? 4'h4 : 4'h8;
			`GPC_DM_SLOWUP_HIZ: drive_of = bit_val ? 4'h9 : 4'h0;
			`GPC_DM_SLOW: drive_of = 4'h9;
			`GPC_DM_HIZ_SLOWDN: drive_of = bit_val ? 4'h0 : 4'h9;
			default: drive_of = 4'h0;
			endcase
		end
	endfunction

	// ************************************************************
	// Pin state
	// ************************************************************
	reg [7:0] level_reg [0:`GPC_NUM_PIN-1];
	reg [3:0] cfg_reg [0:`GPC_NUM_PIN-1];
	reg [7:0] boot_level_reg [0:`GPC_NUM_PIN-1];
	reg [3:0] boot_cfg_reg [0:`GPC_NUM_PIN-1];
	reg [`GPC_NUM_IO-1:0] sync1_reg, sync2_reg, sync3_reg;
	reg [`GPC_NUM_IO-1:0] sample_reg, rise_reg, fall_reg;
	reg sampled_once_reg;
	reg [31:0] sample_cnt_reg;
	reg [31:0] step_cnt_reg;
	reg [6:0] phase_reg;
	reg [7:0] cmd_reg, rsp_reg;
	reg [31:0] data_reg, rdata_reg;
	reg go_reg;
	wire sample_tick = (sample_cnt_reg == SAMPLE_CYC - 1);
	wire step_tick = (step_cnt_reg == PWM_STEP_CYC - 1);

	// ************************************************************
	// Timebases: 32 Hz sampler and 100 Hz PWM phase
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_cnt_reg <= 32'h00000000;
			step_cnt_reg <= 32'h00000000;
			phase_reg <= 7'h00;
		end else begin
			// Free running, never restarted by commands
			sample_cnt_reg <= sample_tick ? 32'h00000000 : sample_cnt_reg + 32'h00000001;
			step_cnt_reg <= step_tick ? 32'h00000000 : step_cnt_reg + 32'h00000001;
			if (step_tick)
				phase_reg <= (phase_reg == `GPC_PWM_LAST) ? 7'h00 : phase_reg + 7'h01;
		end
	end

	// ************************************************************
	// Pin input synchroniser
	// ************************************************************
	// Pin inputs pass three flops; a change is taken once stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= {`GPC_NUM_IO{1'b0}};
			sync2_reg <= {`GPC_NUM_IO{1'b0}};
			sync3_reg <= {`GPC_NUM_IO{1'b0}};
		end else begin
			sync1_reg <= io_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// ************************************************************
	// Command fields held in DATA: index, level, configuration
	// ************************************************************
	wire [7:0] d_idx = data_reg[7:0];
	wire [7:0] d_lvl = data_reg[15:8];
	wire [7:0] d_cfg = data_reg[23:16];

	// ************************************************************
	// Edge detection on the slow samples
	// ************************************************************
	wire [`GPC_NUM_IO-1:0] stable_in;
	wire [`GPC_NUM_IO-1:0] new_rise;
	wire [`GPC_NUM_IO-1:0] new_fall;
	// The very first sample only sets the level, so reset cannot show up as an edge
	wire edge_window = sample_tick && sampled_once_reg;
	genvar g;
	generate
		for (g = 0; g < `GPC_NUM_IO; g = g + 1) begin : edge_gen
			// Stages two and three must agree; otherwise the previous sample is kept
			assign stable_in[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : sample_reg[g];
			assign new_rise[g] = edge_window && stable_in[g] && !sample_reg[g];
			assign new_fall[g] = edge_window && !stable_in[g] && sample_reg[g];
		end
	endgenerate

	// ************************************************************
	// Address decode and command strobes
	// ************************************************************
	wire rd_cmd = go_reg && (cmd_reg == `GPC_CMD_READ);
	wire set_cmd = go_reg && (cmd_reg == `GPC_CMD_SET);
	wire [`GPC_NUM_IO-1:0] clr_mask = (rd_cmd && is_io(d_idx)) ? (5'h01 << d_idx[2:0]) : 5'h00;
	wire hit_cmd = (paddr == `GPC_ADDR_CMD);
	wire hit_data = (paddr == `GPC_ADDR_DATA);
	wire hit_boot = (paddr == `GPC_ADDR_BOOT);
	wire apb_wr = psel && penable && pwrite && pready;
	wire boot_wr = apb_wr && hit_boot;
	wire cmd_wr = apb_wr && hit_cmd;
	// Read answer: configuration, level, state, index; unknown indices answer all zero
	wire [7:0] rd_state = is_io(d_idx) ?
		status_of(rise_reg[d_idx[2:0]], fall_reg[d_idx[2:0]], sample_reg[d_idx[2:0]]) :
		8'h00;
	wire [31:0] read_answer = valid_index(d_idx) ?
		{4'h0, cfg_reg[d_idx[3:0]], level_reg[d_idx[3:0]], rd_state, d_idx} : 32'h00000000;
	integer i;
	integer j;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_reg <= {`GPC_NUM_IO{1'b0}};
			rise_reg <= {`GPC_NUM_IO{1'b0}};
			fall_reg <= {`GPC_NUM_IO{1'b0}};
			sampled_once_reg <= 1'b0;
		end else begin
			if (sample_tick) begin
				sample_reg <= stable_in;
				sampled_once_reg <= 1'b1;
			end
			// New edges win over the clear of a concurrent read
			rise_reg <= (rise_reg & ~clr_mask) | new_rise;
			fall_reg <= (fall_reg & ~clr_mask) | new_fall;
		end
	end

	// Boot copy: only a store request touches it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `GPC_NUM_PIN; i = i + 1) begin
				boot_level_reg[i] <= 8'h00;
				boot_cfg_reg[i] <= {1'b0, `GPC_DM_HIZ};
			end
		end else if (boot_wr && pwdata[`GPC_BOOT_STORE_BIT]) begin
			for (i = 0; i < `GPC_NUM_PIN; i = i + 1) begin
				boot_level_reg[i] <= level_reg[i];
				boot_cfg_reg[i] <= cfg_reg[i];
			end
		end
	end

	// Live pin settings; a restore from the boot copy outranks a command in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < `GPC_NUM_PIN; j = j + 1) begin
				level_reg[j] <= 8'h00;
				cfg_reg[j] <= {1'b0, `GPC_DM_HIZ};
			end
		end else if (boot_wr && pwdata[`GPC_BOOT_LOAD_BIT]) begin
			for (j = 0; j < `GPC_NUM_PIN; j = j + 1) begin
				level_reg[j] <= boot_level_reg[j];
				cfg_reg[j] <= boot_cfg_reg[j];
			end
		end else if (set_cmd && valid_index(d_idx)) begin
			// Invalid fields are dropped one by one, the rest of the command still applies
			if (level_ok(d_lvl))
				level_reg[d_idx[3:0]] <= d_lvl;
			if (data_reg[31:24] == `GPC_LEN_SET_CFG && cfg_ok(d_cfg))
				cfg_reg[d_idx[3:0]] <= is_io(d_idx) ? d_cfg[3:0] : {1'b0, d_cfg[2:0]};
		end
	end

	// ************************************************************
	// Replies: response code and read answer
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_reg <= `GPC_RSP_NONE;
			rdata_reg <= 32'h00000000;
		end else if (set_cmd) begin
			rsp_reg <= `GPC_RSP_SET;
			rdata_reg <= 32'h00000000;
		end else if (rd_cmd) begin
			rsp_reg <= `GPC_RSP_READ;
			rdata_reg <= read_answer;
		end else if (cmd_wr) begin
			// Every CMD write clears the response; a known command code sets it again one cycle later
			rsp_reg <= `GPC_RSP_NONE;
		end
	end

	// ************************************************************
	// APB slave: CMD write launches the command held in DATA
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= 8'h00;
			data_reg <= 32'h00000000;
			go_reg <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			go_reg <= cmd_wr;
			// Answer prepared in the setup cycle, so each access phase ends at its first edge
			pready <= psel && !pready;
			pslverr <= 1'b0;
			if (cmd_wr)
				cmd_reg <= pwdata[7:0];
			if (apb_wr && hit_data)
				data_reg <= pwdata;
			if (psel && !pready) begin
				case (paddr)
				`GPC_ADDR_CMD: prdata <= {24'h000000, cmd_reg};
				`GPC_ADDR_DATA: prdata <= data_reg;
				`GPC_ADDR_RSP: prdata <= {24'h000000, rsp_reg};
				`GPC_ADDR_RDATA: prdata <= rdata_reg;
				`GPC_ADDR_BOOT: prdata <= 32'h00000000;
				default: begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
				endcase
			end
		end
	end

	// ************************************************************
	// Pin drive: PWM compare then drive mode mapping
	// ************************************************************
	reg [`GPC_NUM_PIN-1:0] want_reg;
	wire [`GPC_NUM_PIN-1:0] want_next;
	wire [`GPC_NUM_PIN-1:0] drv_oe;
	wire [`GPC_NUM_PIN-1:0] drv_pu;
	wire [`GPC_NUM_PIN-1:0] drv_pd;
	wire [`GPC_NUM_PIN-1:0] drv_slow;
	wire [`GPC_NUM_IO-1:0] user_next;
	generate
		for (g = 0; g < `GPC_NUM_PIN; g = g + 1) begin : drive_gen
			assign want_next[g] = ({1'b0, phase_reg} < level_reg[g]);
			assign {drv_oe[g], drv_pu[g], drv_pd[g], drv_slow[g]} = drive_of(cfg_reg[g][2:0], want_reg[g]);
		end
		for (g = 0; g < `GPC_NUM_IO; g = g + 1) begin : role_gen
			// Default role logic takes the pin when this is low; drive mode still applies
			assign user_next[g] = cfg_reg[g][`GPC_CFG_FUNC_BIT];
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			want_reg <= {`GPC_NUM_PIN{1'b0}};
			io_out <= 5'h00;
			io_oe <= 5'h00;
			io_pull_up <= 5'h00;
			io_pull_down <= 5'h00;
			io_slow <= 5'h00;
			io_user_mode <= 5'h00;
			output_only_line <= 8'h00;
			output_only_oe <= 8'h00;
			output_only_slow <= 8'h00;
		end else begin
			want_reg <= want_next;
			io_out <= want_reg[`GPC_NUM_IO-1:0];
			io_oe <= drv_oe[`GPC_NUM_IO-1:0];
			io_pull_up <= drv_pu[`GPC_NUM_IO-1:0];
			io_pull_down <= drv_pd[`GPC_NUM_IO-1:0];
			io_slow <= drv_slow[`GPC_NUM_IO-1:0];
			io_user_mode <= user_next;
			// The LED lines have no pulls of their own, so any drive request enables them
			output_only_line <= want_reg[`GPC_NUM_PIN-1:`GPC_NUM_IO];
			output_only_oe <= drv_oe[`GPC_NUM_PIN-1:`GPC_NUM_IO] | drv_pu[`GPC_NUM_PIN-1:`GPC_NUM_IO]
				| drv_pd[`GPC_NUM_PIN-1:`GPC_NUM_IO];
			output_only_slow <= drv_slow[`GPC_NUM_PIN-1:`GPC_NUM_IO];
		end
	end

endmodule
`default_nettype wire

// *** verification/gpc_pin_model.sv ***
// Pin load model: resolves each bidirectional pin from every party driving it
`default_nettype none
module gpc_pin_model (
	input wire logic pclk,
	input wire logic [4:0] io_out,
	input wire logic [4:0] io_oe,
	input wire logic [4:0] io_pull_up,
	input wire logic [4:0] io_pull_down,
	input wire logic [4:0] ext_en,
	input wire logic [4:0] ext_val,
	output logic [4:0] io_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic flip = 1'b0;
	// A floating pin wanders, so a stale level can never pass for a driven one
	always @(posedge pclk) flip <= !flip;
	always_comb
		for (int i = 0; i < 5; i++)
			io_in[i] = io_oe[i] ? io_out[i] : ext_en[i] ? ext_val[i] : io_pull_up[i] | !io_pull_down[i] & flip;
endmodule
`default_nettype wire

// *** verification/gpc_port_properties.sv ***
// Checker: bus handshake and pin drive relations of the port controller
`default_nettype none
`include "gpc_defines.vh"
module gpc_port_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [4:0] io_out,
	input wire logic [4:0] io_oe,
	input wire logic [4:0] io_pull_up,
	input wire logic [4:0] io_pull_down,
	input wire logic [4:0] io_user_mode
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] since_cfg;
	logic mapped;
	assign mapped = paddr <= `GPC_ADDR_BOOT && paddr[1:0] == 2'b00;
	// Cycles since the last command or boot write; saturates so it never wraps
	always @(posedge pclk or negedge presetn)
		if (!presetn) since_cfg <= 4'hF;
		else if (pready && pwrite && (paddr == `GPC_ADDR_CMD || paddr == `GPC_ADDR_BOOT)) since_cfg <= 4'h0;
		else if (since_cfg != 4'hF) since_cfg <= since_cfg + 4'h1;
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_wait;
		psel && penable && !pready;
	endsequence
	sequence answered;
		psel && penable && pready;
	endsequence
	ready_bound_a: assert property (access_wait |=> answered) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
	err_decode_a: assert property (pready |-> pslverr == !mapped) else $error("bad decode");
	err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
	cfg_cause_a: assert property ($changed(io_user_mode) |-> since_cfg < 4'h8) else $error("mode drift");
	drive_excl_a: assert property (((io_pull_up & io_pull_down) | (io_oe & (io_pull_up | io_pull_down))) == 5'h0)
		else $error("drive clash");
	reset_quiet_a: assert property ($rose(presetn) |-> (io_oe == 5'h0 && io_out == 5'h0) [*2])
		else $error("reset drive");
endmodule
bind gpc_port_control gpc_port_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_out(io_out),
	.io_oe(io_oe), .io_pull_up(io_pull_up), .io_pull_down(io_pull_down), .io_user_mode(io_user_mode));
`default_nettype wire

// *** verification/tb_gpio_pwm_port_control.sv ***
// Testbench: drives the port controller over the register bus and checks pins and replies
`default_nettype none
`include "gpc_defines.vh"
module tb_gpio_pwm_port_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, last_err;
	logic [4:0] io_in, io_out, io_oe, io_pu, io_pd, io_user;
	logic [4:0] ext_en = 5'h1F;
	logic [4:0] ext_val = 5'h00;
	logic [7:0] oo_line, oo_oe;
	logic [4:0] io_sl;
	logic [7:0] oo_sl;
	int failures = 0;
	int comparisons = 0;
	gpc_port_control #(.SAMPLE_CYC(16), .PWM_STEP_CYC(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .io_pull_up(io_pu), .io_pull_down(io_pd),
		.io_slow(io_sl), .io_user_mode(io_user), .output_only_line(oo_line), .output_only_oe(oo_oe),
		.output_only_slow(oo_sl));
	gpc_pin_model pins (.pclk(pclk), .io_out(io_out), .io_oe(io_oe), .io_pull_up(io_pu), .io_pull_down(io_pd),
		.ext_en(ext_en), .ext_val(ext_val), .io_in(io_in));
	initial forever #12.5 pclk = !pclk;
	// ****************
	// Bus and command tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		chk("pready", 1'b1, pready);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmd(input logic [7:0] c, i, l, f, n, e);
		apb(1'b1, `GPC_ADDR_DATA, {n, f, l, i}, r);
		apb(1'b1, `GPC_ADDR_CMD, {24'h0, c}, r);
		apb(1'b0, `GPC_ADDR_RSP, 32'h0, r);
		chk("response", {24'h0, e}, r);
	endtask
	task automatic query(input logic [7:0] i, input logic [31:0] e);
		cmd(`GPC_CMD_READ, i, 8'h00, 8'h00, `GPC_LEN_READ, `GPC_RSP_READ);
		apb(1'b0, `GPC_ADDR_RDATA, 32'h0, r);
		chk("rdata", e, r);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_drive;
		cmd(`GPC_CMD_SET, 8'd1, `GPC_LEVEL_HIGH, 8'h09, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		repeat (48) @(posedge pclk);
		chk("oe_out", 2'b11, {io_oe[1], io_out[1]});
		query(8'd1, 32'h0964_0501);
		cmd(`GPC_CMD_SET, 8'd1, 8'h00, 8'h00, `GPC_LEN_SET_VALUE, `GPC_RSP_SET);
		repeat (48) @(posedge pclk);
		query(8'd1, 32'h0900_0201);
	endtask
	task automatic t_edges;
		cmd(`GPC_CMD_SET, 8'd0, 8'h00, 8'h0A, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		chk("user", 1'b1, io_user[0]);
		query(8'd0, 32'h0A00_0000);
		for (int k = 0; k < 3; k++) begin
			ext_val[0] <= !k[0];
			repeat (48) @(posedge pclk);
		end
		query(8'd0, 32'h0A00_0700);
		query(8'd0, 32'h0A00_0100);
		cmd(`GPC_CMD_SET, 8'd0, 8'h00, 8'h02, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		chk("user", 1'b0, io_user[0]);
	endtask
	task automatic t_gpo;
		for (int m = 0; m < 8; m++) begin
			cmd(`GPC_CMD_SET, 8'(m + 5), `GPC_LEVEL_HIGH, 8'(m + 8), `GPC_LEN_SET_CFG, `GPC_RSP_SET);
			chk("gpo_oe", m != 2 && m < 6, oo_oe[m]);
			chk("gpo_line", 1'b1, oo_line[m]);
			chk("gpo_slow", m == 4 || m == 5, oo_sl[m]);
			query(8'(m + 5), {8'(m), 16'h6400, 8'(m + 5)});
		end
	endtask
	task automatic t_invalid;
		cmd(`GPC_CMD_SET, 8'd1, 8'd101, 8'h00, `GPC_LEN_SET_VALUE, `GPC_RSP_SET);
		cmd(`GPC_CMD_SET, 8'd1, 8'h00, 8'h19, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		cmd(`GPC_CMD_SET, 8'd13, 8'h64, 8'h09, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		query(8'd1, 32'h0900_0001);
		apb(1'b0, 12'h014, 32'h0, r);
		chk("unmapped_err", 32'h1, {31'h0, last_err});
		chk("unmapped_data", 32'h0, r);
	endtask
	task automatic t_pwm;
		int hi = 0;
		cmd(`GPC_CMD_SET, 8'd1, 8'd25, 8'h09, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		repeat (200) begin
			@(posedge pclk);
			if (io_out[1] === 1'b1) hi++;
		end
		chk("duty", 32'd50, hi);
		apb(1'b1, `GPC_ADDR_BOOT, 32'h1, r);
		cmd(`GPC_CMD_SET, 8'd1, 8'h00, 8'h0B, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		apb(1'b1, `GPC_ADDR_BOOT, 32'h2, r);
		cmd(`GPC_CMD_READ, 8'd1, 8'h00, 8'h00, `GPC_LEN_READ, `GPC_RSP_READ);
		apb(1'b0, `GPC_ADDR_RDATA, 32'h0, r);
		chk("boot", 16'h0919, r[31:16]);
		cmd(`GPC_CMD_SET, 8'd1, 8'h00, 8'h0F, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		chk("slow_low", 4'h9, {io_oe[1], io_pu[1], io_pd[1], io_sl[1]});
		cmd(`GPC_CMD_SET, 8'd1, `GPC_LEVEL_HIGH, 8'h0B, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		chk("pull_up", 4'h4, {io_oe[1], io_pu[1], io_pd[1], io_sl[1]});
		cmd(`GPC_CMD_SET, 8'd1, 8'h00, 8'h08, `GPC_LEN_SET_CFG, `GPC_RSP_SET);
		chk("pull_down", 4'h2, {io_oe[1], io_pu[1], io_pd[1], io_sl[1]});
	endtask
	task automatic report_and_stop;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		chk("reset", 10'h0, {io_oe, io_user});
		query(8'd2, 32'h0200_0002);
		t_drive;
		t_edges;
		t_gpo;
		t_invalid;
		t_pwm;
		report_and_stop;
	end
	initial begin
		#(25 * 20000);
		failures++;
		report_and_stop;
	end
endmodule
`default_nettype wire
